//--- hdl/vipc_pkg.sv
// Purpose: constants for the drive-level, indicator and power-save decoder
// Assumes: command bytes arrive one per write strobe, synchronous to clk
// Notes: command codes not printed for the drive-level mode set are
//   held here as plain defaults
// Behaviour
// - drive-level mode accepts only register-set byte
// - register-set loads six low bits, 64 steps
// - loading drive level ends drive-level mode
// - indicator on/off bit0; on arms register set
// - indicator pending refuses others until loaded
// - indicator off is a single-byte command
// - indicator code: off, 1s, 0.5s, steady
// - indicator output follows indicator code, forced off in sleep
// - all-points-on with display off enters power save
// - indicator off gives sleep, on gives standby
// - power save keeps settings and memory access
// - sleep stops oscillator, supply, all drive
// - standby stops supply, static drive continues
// - reset command in standby goes to sleep
// - blanking output low during power save
// - all-points-on bit0 forces all lit
// - reset command restores level and indicator
package vipc_pkg;
  // command byte codes and masks
  localparam logic [7:0] CMD_DISP_ONOFF = 8'hAE;
  localparam logic [7:0] CMD_ALL_POINTS = 8'hA4;
  localparam logic [7:0] CMD_IND_ONOFF = 8'hAC;
  localparam logic [7:0] CMD_SW_RESET = 8'hE2;
  localparam logic [7:0] CMD_VOL_MODE = 8'h81;
  localparam logic [7:0] MASK_BIT0 = 8'hFE;
  // field positions
  localparam int VOL_LSB = 0;
  localparam int VOL_MSB = 5;
  localparam int IND_LSB = 0;
  localparam int IND_MSB = 1;
  // reset values
  localparam logic [5:0] VOL_RESET = 6'h20;
  localparam logic [1:0] IND_RESET = 2'h0;
  // indicator codes
  localparam logic [1:0] IND_OFF = 2'h0;
  localparam logic [1:0] IND_BLINK_SLOW = 2'h1;
  localparam logic [1:0] IND_BLINK_FAST = 2'h2;
  localparam logic [1:0] IND_STEADY = 2'h3;
  // display clock ticks per second of blink timing
  localparam logic [15:0] TICKS_PER_SEC = 16'h0800;
  localparam logic [15:0] TICKS_HALF_SEC = 16'h0400;
  // pending second-byte states
  typedef enum logic [1:0] {VIPC_IDLE, VIPC_VOL_PEND, VIPC_IND_PEND}
    vipc_state_e;
endpackage : vipc_pkg

//--- hdl/vipc_blink.sv
// Purpose: static indicator blink phase generator
// Assumes: tick is a one-cycle pulse per display clock period
// Notes: tick is withheld by the caller while the oscillator is stopped
module vipc_blink (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // display clock tick and mode
  input wire logic tick,
  input wire logic [1:0] mode,
  // indicator drive level
  output logic lit
);
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic phase_reg;
  logic phase_next;
  wire [15:0] half_period;
  wire wrap;

  // interval length chosen by mode, in display clock ticks
  assign half_period = (mode == vipc_pkg::IND_BLINK_FAST) ?
    vipc_pkg::TICKS_HALF_SEC : vipc_pkg::TICKS_PER_SEC;
  assign wrap = tick && (count_reg >= half_period - 16'h0001);
  assign count_next = !tick ? count_reg : (wrap ? 16'h0000 :
    count_reg + 16'h0001);
  assign phase_next = wrap ? !phase_reg : phase_reg;

  // output level per indicator code
  assign lit = (mode == vipc_pkg::IND_STEADY) ||
    (((mode == vipc_pkg::IND_BLINK_SLOW) ||
      (mode == vipc_pkg::IND_BLINK_FAST)) && phase_reg);

  // counter and phase
  always_ff @(posedge clk) begin
    if (reset || mode == vipc_pkg::IND_OFF) begin
      count_reg <= 16'h0000;
      phase_reg <= 1'b1;
    end else begin
      count_reg <= count_next;
      phase_reg <= phase_next;
    end
  end
endmodule : vipc_blink

//--- hdl/vipc_core.sv
// Purpose: decode drive-level, indicator and power-save commands
// Assumes: command_or_data_select low marks a command byte
// Notes: data bytes are passed by untouched in every mode
module vipc_core (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // host write port
  input wire logic write_strobe,
  input wire logic command_or_data_select,
  input wire logic [7:0] write_byte,
  // display clock tick from oscillator divider
  input wire logic disp_clk_tick,
  // settings
  output logic [5:0] drive_level_value,
  output logic [1:0] indicator_blink_select,
  output logic display_on,
  output logic all_points_on,
  // power state and panel controls
  output logic sleep_active,
  output logic standby_active,
  output logic osc_enable,
  output logic supply_enable,
  output logic mux_drive_enable,
  output logic outputs_at_vdd,
  output logic blanking_out_n,
  output logic indicator_segment_out,
  output logic command_pending
);
  vipc_pkg::vipc_state_e state_reg;
  vipc_pkg::vipc_state_e state_next;
  logic [5:0] vol_reg;
  logic [5:0] vol_next;
  logic [1:0] ind_reg;
  logic [1:0] ind_next;
  logic disp_on_reg;
  logic all_on_reg;
  logic standby_reg;
  logic standby_next;
  logic ps_active_reg;
  logic seg_reg;
  wire cmd;
  wire is_disp;
  wire is_all;
  wire is_ind;
  wire is_rst;
  wire is_vol;
  wire idle;
  wire ps_now;
  wire blink_lit;
  wire blink_tick;

  // match a command ignoring its lowest bit
  function automatic logic match_bit0(input logic [7:0] b,
    input logic [7:0] code);
    match_bit0 = (b & vipc_pkg::MASK_BIT0) == code;
  endfunction : match_bit0

  // command decode
  assign cmd = write_strobe && !command_or_data_select;
  assign idle = state_reg == vipc_pkg::VIPC_IDLE;
  assign is_disp = match_bit0(write_byte, vipc_pkg::CMD_DISP_ONOFF);
  assign is_all = match_bit0(write_byte, vipc_pkg::CMD_ALL_POINTS);
  assign is_ind = match_bit0(write_byte, vipc_pkg::CMD_IND_ONOFF);
  assign is_rst = write_byte == vipc_pkg::CMD_SW_RESET;
  assign is_vol = write_byte == vipc_pkg::CMD_VOL_MODE;

  // pending second-byte sequencing
  always_comb begin
    state_next = state_reg;
    vol_next = vol_reg;
    ind_next = ind_reg;
    if (cmd) begin
      case (state_reg)
        vipc_pkg::VIPC_VOL_PEND: begin
          // only register set is possible here
          vol_next = write_byte[vipc_pkg::VOL_MSB:vipc_pkg::VOL_LSB];
          state_next = vipc_pkg::VIPC_IDLE;
        end
        vipc_pkg::VIPC_IND_PEND: begin
          // upper six bits ignored
          ind_next = write_byte[vipc_pkg::IND_MSB:vipc_pkg::IND_LSB];
          state_next = vipc_pkg::VIPC_IDLE;
        end
        vipc_pkg::VIPC_IDLE: begin
          if (is_vol) begin
            state_next = vipc_pkg::VIPC_VOL_PEND;
          end else if (is_ind && write_byte[0]) begin
            state_next = vipc_pkg::VIPC_IND_PEND;
          end else if (is_ind) begin
            ind_next = vipc_pkg::IND_OFF;
          end else if (is_rst) begin
            vol_next = vipc_pkg::VOL_RESET;
            ind_next = vipc_pkg::IND_RESET;
          end
        end
        default: begin
          state_next = vipc_pkg::VIPC_IDLE;
        end
      endcase
    end
  end

  // power save mode: entered by all-on with display off
  assign ps_now = all_on_reg && !disp_on_reg;
  assign standby_next = (ps_now && !ps_active_reg) ? (ind_reg != 2'h0) :
    ((cmd && idle && is_rst) ? 1'b0 : standby_reg);

  // state and settings registers
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= vipc_pkg::VIPC_IDLE;
      vol_reg <= vipc_pkg::VOL_RESET;
      ind_reg <= vipc_pkg::IND_RESET;
      disp_on_reg <= 1'b0;
      all_on_reg <= 1'b0;
      standby_reg <= 1'b0;
      ps_active_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      vol_reg <= vol_next;
      ind_reg <= ind_next;
      // settings kept through power save
      if (cmd && idle && is_disp) begin
        disp_on_reg <= write_byte[0];
      end
      if (cmd && idle && is_all) begin
        all_on_reg <= write_byte[0];
      end
      standby_reg <= standby_next;
      ps_active_reg <= ps_now;
    end
  end

  // blink runs only while the oscillator runs
  assign blink_tick = disp_clk_tick && osc_enable;

  vipc_blink u_blink (
    .clk(clk),
    .reset(reset),
    .tick(blink_tick),
    .mode(ind_reg),
    .lit(blink_lit)
  );

  // indicator segment driven by indicator state, held low while the oscillator is stopped
  always_ff @(posedge clk) begin
    if (reset) begin
      seg_reg <= 1'b0;
    end else begin
      seg_reg <= blink_lit && osc_enable;
    end
  end

  // outputs
  assign drive_level_value = vol_reg;
  assign indicator_blink_select = ind_reg;
  assign display_on = disp_on_reg;
  assign all_points_on = all_on_reg;
  assign sleep_active = ps_active_reg && !standby_reg;
  assign standby_active = ps_active_reg && standby_reg;
  assign osc_enable = !sleep_active;
  assign supply_enable = !ps_active_reg;
  assign mux_drive_enable = !ps_active_reg;
  assign outputs_at_vdd = ps_active_reg;
  assign blanking_out_n = !ps_active_reg;
  assign indicator_segment_out = seg_reg;
  assign command_pending = !idle;
endmodule : vipc_core

//--- tb/vipc_host.sv
// Purpose: host model writing command and data bytes
// Assumes: one byte per strobe, driven on the falling edge
// Notes: byte lines show the inverted value once released
module vipc_host (
  // clock
  input wire logic clk,
  // host write port
  output logic write_strobe,
  output logic command_or_data_select,
  output logic [7:0] write_byte
);
  // idle port at time zero
  initial begin
    write_strobe = 1'b0;
    command_or_data_select = 1'b0;
    write_byte = 8'h00;
  end
  // one strobed byte, then settle time
  task automatic send(input logic d, input logic [7:0] b);
    @(negedge clk);
    write_strobe <= 1'b1;
    command_or_data_select <= d;
    write_byte <= b;
    @(negedge clk);
    write_strobe <= 1'b0;
    write_byte <= ~b;
    repeat (3) @(negedge clk);
  endtask : send
endmodule : vipc_host

//--- tb/vipc_assertions.sv
// Purpose: port checks on the command decoder
// Assumes: one command byte per write_strobe pulse
// Notes: awaited second byte tracked from the byte stream
module vipc_chk (
  // clock, reset, host port
  input wire logic clk, reset, write_strobe, command_or_data_select,
  input wire logic [7:0] write_byte,
  // settings and state
  input wire logic [5:0] drive_level_value,
  input wire logic [1:0] indicator_blink_select,
  input wire logic display_on, all_points_on, sleep_active,
  input wire logic standby_active, osc_enable, supply_enable,
  input wire logic blanking_out_n, command_pending
);
  logic tk, vp, ip;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // taken command and which second byte is awaited
  assign tk = write_strobe && !command_or_data_select;
  always_ff @(posedge clk) begin
    if (reset) begin
      vp <= 1'b0;
      ip <= 1'b0;
    end else if (tk) begin
      vp <= !command_pending && write_byte == vipc_pkg::CMD_VOL_MODE;
      ip <= !command_pending && write_byte == 8'hAD;
    end
  end
  a_level_arm: assert property (tk && !command_pending &&
    write_byte == vipc_pkg::CMD_VOL_MODE |=> command_pending) else $error("no arm");
  a_level_load: assert property (tk && vp |=> !command_pending &&
    drive_level_value == $past(write_byte[5:0])) else $error("level load");
  a_ind_load: assert property (tk && ip |=> !command_pending &&
    indicator_blink_select == $past(write_byte[1:0])) else $error("ind load");
  a_ind_off: assert property (tk && !command_pending &&
    write_byte == vipc_pkg::CMD_IND_ONOFF |=> !command_pending &&
    indicator_blink_select == vipc_pkg::IND_OFF) else $error("ind off");
  a_save_blank: assert property (all_points_on && !display_on
    |-> ##[0:1] !blanking_out_n) else $error("no blanking");
  a_sleep_halt: assert property (sleep_active
    |-> !osc_enable && !supply_enable) else $error("sleep runs");
  a_save_kind: assert property ($fell(blanking_out_n) |->
    (indicator_blink_select == vipc_pkg::IND_OFF) ? sleep_active
    : standby_active) else $error("save kind");
  a_reset_sleep: assert property (standby_active && tk &&
    !command_pending && write_byte == vipc_pkg::CMD_SW_RESET
    |-> ##[1:2] sleep_active)
    else $error("no sleep");
  c_sleep: cover property (sleep_active);
  c_standby: cover property (standby_active);
  c_level: cover property (tk && vp);
endmodule : vipc_chk
bind vipc_core vipc_chk chk_u (.*);

//--- tb/tb_top.sv
// Purpose: self-checking bench for the command decoder
// Assumes: host model drives bytes on the falling edge
// Notes: tick toggles each cycle, so blink spans are doubled
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, write_strobe, command_or_data_select, disp_clk_tick;
  logic [7:0] write_byte;
  logic [5:0] drive_level_value;
  logic [1:0] indicator_blink_select;
  logic display_on, all_points_on, sleep_active, standby_active;
  logic osc_enable, supply_enable, mux_drive_enable, outputs_at_vdd;
  logic blanking_out_n, indicator_segment_out, command_pending;
  int mismatches, total_checks;
  vipc_core dut_u (.*);
  vipc_host host_u (.*);
  // clock and display tick
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial disp_clk_tick = 1'b0;
  always @(negedge clk) disp_clk_tick <= ~disp_clk_tick;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic s(input logic [7:0] b);
    host_u.send(1'b0, b);
  endtask : s
  task automatic t_level;
    s(8'h81);
    s(8'hAF);
    chk({display_on, command_pending, drive_level_value}, 16'h2F);
    s(8'h81);
    s(8'h15); // upper bits zero
    chk(drive_level_value, 16'h15);
  endtask : t_level
  task automatic t_ind;
    s(8'hAD);
    s(8'hA5);
    chk({all_points_on, indicator_blink_select}, 16'h1);
    s(8'hAC);
    chk({command_pending, indicator_blink_select}, 16'h0);
    s(8'hAD);
    s(8'h03);
    s(8'hAF);
    s(8'hA7);
    chk(indicator_segment_out, 16'h1);
    s(8'hAE);
    s(8'hA6);
  endtask : t_ind
  task automatic t_save;
    s(8'hAC);
    s(8'hA5);
    chk({blanking_out_n, sleep_active, osc_enable}, 16'h2);
    chk({mux_drive_enable, outputs_at_vdd, indicator_segment_out},
      16'h2);
    host_u.send(1'b1, 8'h81);
    chk({command_pending, drive_level_value}, 16'h15);
    s(8'hA4);
    chk({blanking_out_n, supply_enable}, 16'h3);
    s(8'hAD);
    s(8'h03);
    s(8'hA5);
    chk({standby_active, osc_enable, blanking_out_n}, 16'h6);
    chk({mux_drive_enable, outputs_at_vdd, indicator_segment_out},
      16'h3);
    s(8'hE2);
    chk({sleep_active, indicator_blink_select, drive_level_value},
      16'h120);
    s(8'hA4);
  endtask : t_save
  task automatic t_blink(input logic [1:0] m, input int t);
    int n;
    logic p;
    n = 0;
    s(8'hAD);
    s({6'h00, m});
    p = indicator_segment_out;
    repeat (8192) begin
      @(negedge clk);
      n += int'(indicator_segment_out !== p);
      p = indicator_segment_out;
    end
    chk(16'(n >= 8192 / (2 * t) - 1 && n <= 8192 / (2 * t) + 1), 16'h1);
  endtask : t_blink
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run
  // watchdog
  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    complete_run;
  end
  // main sequence
  initial begin
    mismatches = 0;
    total_checks = 0;
    reset = 1'b1;
    repeat (4) @(negedge clk);
    reset = 1'b0;
    chk({blanking_out_n, drive_level_value}, 16'h60);
    t_level;
    t_ind;
    t_save;
    t_blink(vipc_pkg::IND_BLINK_FAST, int'(vipc_pkg::TICKS_HALF_SEC));
    t_blink(vipc_pkg::IND_BLINK_SLOW, int'(vipc_pkg::TICKS_PER_SEC));
    complete_run;
  end
endmodule : tb_top
